//--- hw/hpp_host_port.v
// Host parallel peripheral port: pin side of the device
`timescale 1ns/1ps
`default_nettype none
`include "hpp_defs.vh"

module hpp_host_port (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_b,
    // Host bus pins
    input  wire       chipSel_n,
    input  wire       host_rd_wr,
    input  wire [3:0] reg_sel,
    input  wire [7:0] hostDataIn,
    output reg  [7:0] hostDataOut_q,
    output reg        hostDataOe_q,
    // Acknowledge, open drain: drives low while oe is high
    output reg        xfer_ack_n_q,
    output reg        xferAckOe_q,
    // Interrupt, open drain
    output reg        host_irq_n_q,
    output reg        hostIrqOe_q,
    // Port E bit seven pin (host_sync_clk when in host mode)
    input  wire       porte_bit_seven,
    output reg        porteSevenOe_q,
    // Internal processor side
    input  wire       cpuWrEn,
    input  wire [2:0] cpuWrChan,
    input  wire [7:0] cpuWrData,
    input  wire       cpuRdEn,
    input  wire [2:0] cpuRdChan,
    output reg  [7:0] cpuRdData_q,
    output reg        cpuRdValid_q,
    input  wire [7:0] cpuIrqSrc,
    output reg  [7:0] hostToCpuAvail_q
);

    // ----------------------------------------------------------------
    // Synchronisers for pins from the host's domain
    // ----------------------------------------------------------------
    reg [12:0] pinMeta_q;
    reg [12:0] pinSync_q;
    reg        clkPrev_q;
    always @(posedge clk) begin
        if (!rst_b) begin
            pinMeta_q <= 13'h1fff;
            pinSync_q <= 13'h1fff;
            clkPrev_q <= 1'b1;
        end else begin
            pinMeta_q <= {porte_bit_seven, chipSel_n, host_rd_wr, reg_sel,
                          hostDataIn[5:0]};
            pinSync_q <= pinMeta_q;
            clkPrev_q <= pinSync_q[12];
        end
    end
    // Two data bits synchronised separately to keep vectors short
    reg [1:0] dHiMeta_q;
    reg [1:0] dHiSync_q;
    always @(posedge clk) begin
        if (!rst_b) begin
            dHiMeta_q <= 2'h0;
            dHiSync_q <= 2'h0;
        end else begin
            dHiMeta_q <= hostDataIn[7:6];
            dHiSync_q <= dHiMeta_q;
        end
    end

    wire       selS   = !pinSync_q[11];
    wire       readS  = pinSync_q[10];
    wire [3:0] selCode = pinSync_q[9:6];
    wire [7:0] wrByte = {dHiSync_q, pinSync_q[5:0]};
    wire       hclkRise = pinSync_q[12] && !clkPrev_q;

    // ----------------------------------------------------------------
    // Control registers and FIFO memory
    // ----------------------------------------------------------------
    reg  [7:0] ctrl_q [0:6];
    reg  [1:0] state_q;
    wire       isData = !selCode[3];
    wire [2:0] cIdx   = selCode[2:0];
    wire       extClk = ctrl_q[`HPP_CTRL_MODE][`HPP_MODE_EXTCLK];

    // Host writes land in channel, cpu reads drain it; cpu writes to host
    // use the same channel number unchanged, so both directions share each FIFO
    wire       startAcc = (state_q == `HPP_ST_IDLE) && selS;
    wire       hWr = startAcc && !readS && isData;
    wire       hRd = startAcc && readS && isData;
    wire [7:0] notEmpty;
    wire [7:0] isFull;
    wire [7:0] memRd;
    // Host port and cpu share one write port; the host has priority
    wire       mWr   = hWr | cpuWrEn;
    wire [2:0] mWrCh = hWr ? cIdx : cpuWrChan;
    wire [7:0] mWrD  = hWr ? wrByte : cpuWrData;
    wire       mRd   = hRd | (cpuRdEn & !hRd);
    wire [2:0] mRdCh = hRd ? cIdx : cpuRdChan;

    hpp_fifo_mem uFifo (
        .clk      (clk),
        .rst_b    (rst_b),
        .wrEn     (mWr),
        .wrChan   (mWrCh),
        .wrData   (mWrD),
        .rdEn     (mRd),
        .rdChan   (mRdCh),
        .rdData_q (memRd),
        .notEmpty (notEmpty),
        .isFull   (isFull)
    );

    // ----------------------------------------------------------------
    // Access sequencer
    // ----------------------------------------------------------------
    reg        wasRead_q;
    reg        wasData_q;
    reg [2:0]  idx_q;
    reg        cpuPend_q;
    integer    i;
    always @(posedge clk) begin
        if (!rst_b) begin
            state_q      <= `HPP_ST_IDLE;
            wasRead_q    <= 1'b0;
            wasData_q    <= 1'b0;
            idx_q        <= 3'h0;
            xfer_ack_n_q <= 1'b1;
            xferAckOe_q  <= 1'b0;
            hostDataOe_q <= 1'b0;
            hostDataOut_q <= `HPP_RST_BYTE;
            for (i = 0; i < 7; i = i + 1)
                ctrl_q[i] <= `HPP_RST_BYTE;
        end else begin
            case (state_q)
                `HPP_ST_IDLE: begin
                    if (selS) begin
                        wasRead_q <= readS;
                        wasData_q <= isData;
                        idx_q     <= cIdx;
                        if (!readS && !isData && cIdx != 3'h7)
                            ctrl_q[cIdx] <= wrByte;
                        state_q <= extClk ? `HPP_ST_WAITCLK : `HPP_ST_ACK;
                    end
                end
                `HPP_ST_WAITCLK: begin
                    // Ack waits for a rising host clock edge
                    if (!selS)
                        state_q <= `HPP_ST_IDLE;
                    else if (hclkRise)
                        state_q <= `HPP_ST_ACK;
                end
                `HPP_ST_ACK: begin
                    if (wasRead_q) begin
                        hostDataOe_q <= 1'b1;
                        if (wasData_q)
                            hostDataOut_q <= memRd;
                        else if (idx_q == `HPP_CTRL_STAT)
                            hostDataOut_q <= notEmpty;
                        else if (idx_q == 3'h7)
                            hostDataOut_q <= isFull;
                        else
                            hostDataOut_q <= ctrl_q[idx_q];
                    end
                    xfer_ack_n_q <= 1'b0;
                    xferAckOe_q  <= 1'b1;
                    // Held until the host drops chip select
                    if (!selS) begin
                        xfer_ack_n_q <= 1'b1;
                        xferAckOe_q  <= 1'b0;
                        hostDataOe_q <= 1'b0;
                        state_q      <= `HPP_ST_IDLE;
                    end
                end
                default: state_q <= `HPP_ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Interrupt, port E direction and cpu read path
    // ----------------------------------------------------------------
    wire irqAny = |(cpuIrqSrc & ctrl_q[`HPP_CTRL_IMASK]);
    always @(posedge clk) begin
        if (!rst_b) begin
            host_irq_n_q     <= 1'b1;
            hostIrqOe_q      <= 1'b0;
            porteSevenOe_q   <= 1'b0;
            cpuPend_q        <= 1'b0;
            cpuRdValid_q     <= 1'b0;
            cpuRdData_q      <= `HPP_RST_BYTE;
            hostToCpuAvail_q <= 8'h00;
        end else begin
            host_irq_n_q     <= !irqAny;
            hostIrqOe_q      <= irqAny;
            porteSevenOe_q   <= 1'b0;
            cpuPend_q        <= cpuRdEn & !hRd;
            cpuRdValid_q     <= cpuPend_q;
            hostToCpuAvail_q <= notEmpty;
            if (cpuPend_q)
                cpuRdData_q <= memRd;
        end
    end

endmodule // hpp_host_port
`default_nettype wire

//--- hw/hpp_defs.vh
// Constants for the host parallel peripheral port
`ifndef HPP_DEFS_VH
`define HPP_DEFS_VH

// ----------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------
`define HPP_DATA_W      8
`define HPP_SEL_W       4
`define HPP_FIFO_DEPTH  4
`define HPP_PTR_W       2
`define HPP_NUM_DATA    8
`define HPP_NUM_CTRL    7

// ----------------------------------------------------------------
// Register select codes: 0..7 data FIFOs, 8..14 control
// ----------------------------------------------------------------
`define HPP_SEL_CTRL0   4'h8
`define HPP_CTRL_STAT   3'h0
`define HPP_CTRL_IMASK  3'h1
`define HPP_CTRL_MODE   3'h2
`define HPP_MODE_EXTCLK 0
`define HPP_RST_BYTE    8'h00

// ----------------------------------------------------------------
// Access state machine codes
// ----------------------------------------------------------------
`define HPP_ST_IDLE     2'h0
`define HPP_ST_WAITCLK  2'h1
`define HPP_ST_ACK      2'h2

`endif

//--- hw/hpp_fifo_mem.v
// Eight 4-deep byte FIFOs in one small memory with registered read
`timescale 1ns/1ps
`default_nettype none
`include "hpp_defs.vh"

module hpp_fifo_mem (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_b,
    // Write side
    input  wire       wrEn,
    input  wire [2:0] wrChan,
    input  wire [7:0] wrData,
    // Read side
    input  wire       rdEn,
    input  wire [2:0] rdChan,
    output reg  [7:0] rdData_q,
    // Per-channel occupancy flags
    output wire [7:0] notEmpty,
    output wire [7:0] isFull
);

    reg [7:0] mem [0:31];
    reg [1:0] wrPtr_q [0:7];
    reg [1:0] rdPtr_q [0:7];
    reg [2:0] cnt_q   [0:7];

    // ----------------------------------------------------------------
    // Per-channel pointers and counts
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : gChan
            wire doWr = wrEn && (wrChan == g) && (cnt_q[g] != 3'd4);
            wire doRd = rdEn && (rdChan == g) && (cnt_q[g] != 3'd0);
            // Writes to a full FIFO and reads of an empty one are dropped
            always @(posedge clk) begin
                if (!rst_b) begin
                    wrPtr_q[g] <= 2'h0;
                    rdPtr_q[g] <= 2'h0;
                    cnt_q[g]   <= 3'h0;
                end else begin
                    if (doWr)
                        wrPtr_q[g] <= wrPtr_q[g] + 2'h1;
                    if (doRd)
                        rdPtr_q[g] <= rdPtr_q[g] + 2'h1;
                    cnt_q[g] <= cnt_q[g] + {2'h0, doWr} - {2'h0, doRd};
                end
            end
            assign notEmpty[g] = (cnt_q[g] != 3'd0);
            assign isFull[g]   = (cnt_q[g] == 3'd4);
        end
    endgenerate

    // Storage write; no reset on the array itself
    always @(posedge clk) begin
        if (wrEn && !isFull[wrChan])
            mem[{wrChan, wrPtr_q[wrChan]}] <= wrData;
    end

    // Registered head of the selected FIFO
    always @(posedge clk) begin
        if (!rst_b)
            rdData_q <= `HPP_RST_BYTE;
        else if (rdEn)
            rdData_q <= mem[{rdChan, rdPtr_q[rdChan]}];
    end

endmodule // hpp_fifo_mem
`default_nettype wire

//--- tb/hpp_checker.sv
// Pin-level assertion checker for the host parallel port
`timescale 1ns/1ps
`default_nettype none
module hpp_checker (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_b,
    // Host pins
    input wire logic       chipSel_n,
    input wire logic       host_rd_wr,
    input wire logic       hostDataOe_q,
    input wire logic       xfer_ack_n_q,
    input wire logic       xferAckOe_q,
    input wire logic       host_irq_n_q,
    input wire logic       hostIrqOe_q,
    input wire logic       porteSevenOe_q,
    // Processor side
    input wire logic       cpuRdEn,
    input wire logic       cpuRdValid_q,
    input wire logic [7:0] cpuIrqSrc
);
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_b);
// ------------------------------------------------------------
// Sequences, six idle cycles cover the sync and release delay
// ------------------------------------------------------------
sequence s_idle; chipSel_n [*6]; endsequence
sequence s_start; $fell(chipSel_n) ##1 !chipSel_n; endsequence
property p_ack_idle; s_idle |-> !xferAckOe_q; endproperty
a_ack_idle: assert property (p_ack_idle) else $error("ack driven while idle");
property p_bus_idle; s_idle |-> !hostDataOe_q; endproperty
a_bus_idle: assert property (p_bus_idle) else $error("data driven while idle");
property p_wr_quiet; (!host_rd_wr) [*6] |-> !hostDataOe_q; endproperty
a_wr_quiet: assert property (p_wr_quiet) else $error("data driven in write");
property p_ack_due; s_start |-> ##[1:60] (xferAckOe_q || chipSel_n); endproperty
a_ack_due: assert property (p_ack_due) else $error("ack missing");
property p_ack_low; xferAckOe_q |-> !xfer_ack_n_q; endproperty
a_ack_low: assert property (p_ack_low) else $error("ack driven high");
property p_ack_free; $rose(chipSel_n) |-> ##[1:6] !xferAckOe_q; endproperty
a_ack_free: assert property (p_ack_free) else $error("ack not released");
property p_irq_off; (cpuIrqSrc == 8'h00) [*3] |-> !hostIrqOe_q; endproperty
a_irq_off: assert property (p_irq_off) else $error("irq without cause");
property p_irq_low; hostIrqOe_q |-> !host_irq_n_q; endproperty
a_irq_low: assert property (p_irq_low) else $error("irq driven high");
property p_pe7_in; !porteSevenOe_q; endproperty
a_pe7_in: assert property (p_pe7_in) else $error("port pin driven");
property p_cpu_rd; cpuRdEn |-> ##2 cpuRdValid_q; endproperty
a_cpu_rd: assert property (p_cpu_rd) else $error("pop data late");
endmodule // hpp_checker
bind hpp_host_port hpp_checker u_chk (.clk, .rst_b, .chipSel_n, .host_rd_wr, .hostDataOe_q,
    .xfer_ack_n_q, .xferAckOe_q, .host_irq_n_q, .hostIrqOe_q, .porteSevenOe_q, .cpuRdEn,
    .cpuRdValid_q, .cpuIrqSrc);
`default_nettype wire

//--- tb/hpp_host_model.sv
// Behavioural host processor on the asynchronous parallel bus
`timescale 1ns/1ps
`default_nettype none
module hpp_host_model (
    // Clock
    input wire logic        clk,
    // Host bus pins
    output var logic        chipSel_n,
    output var logic        host_rd_wr,
    output var logic [3:0]  reg_sel,
    output var logic [7:0]  hostDataIn,
    output var logic        porte_bit_seven,
    input wire logic [7:0]  hostDataOut_q,
    input wire logic        hostDataOe_q,
    input wire logic        xfer_ack_n_q,
    input wire logic        xferAckOe_q
);
wire ackLine = xferAckOe_q ? xfer_ack_n_q : 1'b1; // Pull-up holds the idle level
// Idle pins at time zero
initial begin
    chipSel_n = 1;
    host_rd_wr = 1;
    reg_sel = 0;
    hostDataIn = 8'h5a;
    porte_bit_seven = 0;
end
// Link clock runs at 80 ns only inside a frame, each edge 2 ns before a clk rise
initial begin
    #3;
    forever #40 if (!chipSel_n) porte_bit_seven = ~porte_bit_seven;
end
// One transfer: hold everything until ack is seen, then release
task automatic access(input logic rd, input logic [3:0] sel, input logic [7:0] wd,
                      output logic [7:0] rdat, output logic ok);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    host_rd_wr = rd;
    reg_sel = sel;
    hostDataIn = rd ? ~hostDataIn : wd;
    chipSel_n = 0;
    while (ackLine !== 1'b0 && n < 60) begin @(posedge clk); #1; n++; end
    ok = (ackLine === 1'b0) && (!rd || hostDataOe_q === 1'b1);
    rdat = hostDataOut_q;
    chipSel_n = 1;
    hostDataIn = ~hostDataIn; // Released lines do not keep the old byte
    n = 0;
    while (ackLine !== 1'b1 && n < 10) begin @(posedge clk); #1; n++; end
endtask
endmodule // hpp_host_model
`default_nettype wire

//--- tb/hpp_host_port_tb_top.sv
// Top-level self-checking testbench for the host parallel port
`timescale 1ns/1ps
`default_nettype none
module hpp_host_port_tb_top;
logic       clk = 0, rst_b = 0, chipSel_n, host_rd_wr, porte_bit_seven, ok;
logic [3:0] reg_sel;
logic [7:0] hostDataIn, rdV;
wire  [7:0] hostDataOut_q, cpuRdData_q, hostToCpuAvail_q;
wire        hostDataOe_q, xfer_ack_n_q, xferAckOe_q, host_irq_n_q, hostIrqOe_q;
wire        porteSevenOe_q, cpuRdValid_q;
logic       cpuWrEn = 0, cpuRdEn = 0;
logic [2:0] cpuWrChan = 0, cpuRdChan = 0;
logic [7:0] cpuWrData = 0, cpuIrqSrc = 0;
int         fails = 0, samples_checked = 0;
// 100 MHz clock
always #5 clk = ~clk;
hpp_host_port uut (.clk, .rst_b, .chipSel_n, .host_rd_wr, .reg_sel, .hostDataIn,
    .hostDataOut_q, .hostDataOe_q, .xfer_ack_n_q, .xferAckOe_q, .host_irq_n_q, .hostIrqOe_q,
    .porte_bit_seven, .porteSevenOe_q, .cpuWrEn, .cpuWrChan, .cpuWrData, .cpuRdEn,
    .cpuRdChan, .cpuRdData_q, .cpuRdValid_q, .cpuIrqSrc, .hostToCpuAvail_q);
hpp_host_model host (.clk, .chipSel_n, .host_rd_wr, .reg_sel, .hostDataIn, .porte_bit_seven,
    .hostDataOut_q, .hostDataOe_q, .xfer_ack_n_q, .xferAckOe_q);
// ------------------------------------------------------------
// Shared tasks
// ------------------------------------------------------------
task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
        fails++;
        $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
endtask
task automatic xfer(input logic rd, input logic [3:0] sel, input logic [7:0] wd);
    host.access(rd, sel, wd, rdV, ok);
    chk("ack", 8'h01, {7'h00, ok});
endtask
task automatic t_reset;
    chk("idle pins", 8'h03, {2'b00, hostDataOe_q, xferAckOe_q, hostIrqOe_q, porteSevenOe_q,
        xfer_ack_n_q, host_irq_n_q});
    $display("t_reset done");
endtask
// Fill a FIFO past full, then drain it in order; the fifth byte is refused
task automatic t_fifo;
    for (int i = 0; i < 5; i++) xfer(0, 4'h3, 8'(1 << i));
    chk("avail", 8'h08, hostToCpuAvail_q);
    xfer(1, 4'h8, 8'h00);
    chk("status", 8'h08, rdV);
    xfer(1, 4'hf, 8'h00);
    chk("full flags", 8'h08, rdV);
    for (int i = 0; i < 4; i++) begin
        xfer(1, 4'h3, 8'h00);
        chk("fifo byte", 8'(1 << i), rdV);
    end
    xfer(1, 4'h8, 8'h00);
    chk("status", 8'h00, rdV);
    $display("t_fifo done");
endtask
// Bytes cross between processor and host both ways
task automatic t_cpu;
    int n;
    n = 0;
    @(posedge clk); #1 cpuWrEn = 1; cpuWrChan = 3'h5; cpuWrData = 8'hc3;
    @(posedge clk); #1 cpuWrEn = 0;
    xfer(1, 4'h5, 8'h00);
    chk("cpu to host", 8'hc3, rdV);
    xfer(0, 4'h6, 8'h3c);
    @(posedge clk); #1 cpuRdEn = 1; cpuRdChan = 3'h6;
    @(posedge clk); #1 cpuRdEn = 0;
    while (cpuRdValid_q !== 1'b1 && n < 4) begin @(posedge clk); #1; n++; end
    chk("host to cpu", 8'h3c, cpuRdData_q);
    $display("t_cpu done");
endtask
// Interrupt masked, enabled, then cause removed
task automatic t_irq;
    cpuIrqSrc = 8'h04;
    xfer(0, 4'h9, 8'h00);
    repeat (4) @(posedge clk);
    #1;
    chk("irq masked", 8'h01, {6'h00, hostIrqOe_q, host_irq_n_q});
    xfer(0, 4'h9, 8'h04);
    xfer(1, 4'h9, 8'h00);
    chk("mask readback", 8'h04, rdV);
    repeat (4) @(posedge clk);
    #1;
    chk("irq on", 8'h02, {6'h00, hostIrqOe_q, host_irq_n_q});
    cpuIrqSrc = 8'h00;
    repeat (4) @(posedge clk);
    #1;
    chk("irq off", 8'h01, {6'h00, hostIrqOe_q, host_irq_n_q});
    $display("t_irq done");
endtask
// Acknowledge paced by the host link clock
task automatic t_ext;
    xfer(0, 4'ha, 8'h01);
    xfer(0, 4'h0, 8'h77);
    xfer(1, 4'h0, 8'h00);
    chk("ext read", 8'h77, rdV);
    xfer(0, 4'ha, 8'h00);
    $display("t_ext done");
endtask
task automatic results;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
endtask
// Main sequence
initial begin
    repeat (8) @(posedge clk);
    #1 rst_b = 1;
    repeat (3) @(posedge clk);
    #1;
    t_reset;
    t_fifo;
    t_cpu;
    t_irq;
    t_ext;
    results;
end
// Watchdog, well beyond the twenty-one transfers' worth of cycles
initial begin
    #200000;
    fails++;
    results;
end
endmodule // hpp_host_port_tb_top
`default_nettype wire
